// >>> src/dds_defs.vh
// constants for the dual dac serial update control block
`ifndef DDS_DEFS_VH
`define DDS_DEFS_VH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define DDS_FRAME_BITS 24
`define DDS_FRAME_CNT 5'h18
`define DDS_CNT_MAX 5'h1F
`define DDS_CNT_W 5
`define DDS_DATA_W 16
`define DDS_RW_BIT 23
`define DDS_REG_HI 21
`define DDS_REG_LO 19
`define DDS_CH_HI 18
`define DDS_CH_LO 16
`define DDS_DATA_HI 15
`define DDS_DATA_LO 0

// ----------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------
`define DDS_REG_DAC 3'h0
`define DDS_REG_RANGE 3'h1
`define DDS_REG_POWER 3'h2
`define DDS_REG_CTRL 3'h3

// ----------------------------------------------------------------
// channel address codes, and control-register sub addresses
// ----------------------------------------------------------------
`define DDS_CH_A 3'h0
`define DDS_CH_B 3'h1
`define DDS_CH_ALL 3'h4
`define DDS_CTRL_NOP 3'h0
`define DDS_CTRL_SET 3'h1
`define DDS_CTRL_CLEAR 3'h4

// ----------------------------------------------------------------
// control field positions and widths
// ----------------------------------------------------------------
`define DDS_SDO_DIS_BIT 0
`define DDS_CLR_SEL_BIT 1
`define DDS_RANGE_W 3
`define DDS_RANGE_HI 2
`define DDS_PWR_A_BIT 0
`define DDS_PWR_B_BIT 1

// ----------------------------------------------------------------
// range codes and code values
// ----------------------------------------------------------------
`define DDS_RANGE_UNI5 3'h0
`define DDS_RANGE_UNI10 3'h1
`define DDS_RANGE_UNI108 3'h2
`define DDS_RANGE_BIP5 3'h3
`define DDS_RANGE_BIP10 3'h4
`define DDS_RANGE_BIP108 3'h5
`define DDS_CODE_ZERO 16'h0000
`define DDS_CODE_MID 16'h8000
`define DDS_SIGN_FLIP 16'h8000
`define DDS_RB_PAD 8'h00

`endif

// >>> src/dds_frame_rx.v
// serial link front end: pin sampling, 24-bit shifter, frame check
`default_nettype none
`include "dds_defs.vh"

module dds_frame_rx (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    input wire clk_en_i,
    // link pins
    input wire sclk_i,
    input wire frame_sync_n_i,
    input wire serial_in_i,
    // readback load
    input wire load_i,
    input wire [`DDS_FRAME_BITS-1:0] load_word_i,
    // frame results
    output reg frame_end_o,
    output reg frame_ok_o,
    output reg [`DDS_FRAME_BITS-1:0] word_o,
    output reg frame_idle_o,
    output reg serial_out_o
);

// ----------------------------------------------------------------
// pin synchronisers: bit0 clock, bit1 sync, bit2 data
// ----------------------------------------------------------------
reg [2:0] pin_s1_r;
reg [2:0] pin_s2_r;
reg sclk_d_r;
reg [`DDS_FRAME_BITS-1:0] sr_r;
reg [`DDS_CNT_W-1:0] cnt_r;

wire sclk_fall = sclk_d_r & ~pin_s2_r[0];
wire sclk_rise = ~sclk_d_r & pin_s2_r[0];
wire active = ~pin_s2_r[1];
wire sync_fall = frame_idle_o & ~pin_s2_r[1];
wire sync_rise = ~frame_idle_o & pin_s2_r[1];
wire shift_en = active & sclk_fall;

// ----------------------------------------------------------------
// shifting and counting
// ----------------------------------------------------------------
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        pin_s1_r <= 3'h3;
        pin_s2_r <= 3'h3;
        sclk_d_r <= 1'b1;
        frame_idle_o <= 1'b1;
        sr_r <= {`DDS_FRAME_BITS{1'b0}};
        cnt_r <= {`DDS_CNT_W{1'b0}};
        serial_out_o <= 1'b0;
        frame_end_o <= 1'b0;
        frame_ok_o <= 1'b0;
        word_o <= {`DDS_FRAME_BITS{1'b0}};
    end else if (clk_en_i) begin
        pin_s1_r <= {serial_in_i, frame_sync_n_i, sclk_i};
        pin_s2_r <= pin_s1_r;
        sclk_d_r <= pin_s2_r[0];
        frame_idle_o <= pin_s2_r[1];
        frame_end_o <= 1'b0;
        if (shift_en)
            sr_r <= {sr_r[`DDS_FRAME_BITS-2:0], pin_s2_r[2]};
        else if (load_i)
            sr_r <= load_word_i;
        if (sync_fall)
            cnt_r <= shift_en ? 5'h01 : 5'h00;
        else if (shift_en && cnt_r != `DDS_CNT_MAX)
            cnt_r <= cnt_r + 5'h01;
        // oldest bit leaves on rising edge
        // msb shown at frame start so the first fall can take it
        if (sync_fall)
            serial_out_o <= sr_r[`DDS_FRAME_BITS-1];
        else if (active && sclk_rise)
            serial_out_o <= sr_r[`DDS_FRAME_BITS-1];
        if (sync_rise) begin
            frame_end_o <= 1'b1;
            frame_ok_o <= (cnt_r == `DDS_FRAME_CNT);
            word_o <= sr_r;
        end
    end
end

endmodule

`default_nettype wire

// >>> src/dds_serial_ctrl.v
// dual dac digital front end: frame decode, registers, update, clear
`default_nettype none
`include "dds_defs.vh"

module dds_serial_ctrl (
    // clock, enable and reset
    input wire core_clk_i,
    input wire clk_en_i,
    input wire reset_n_i,
    // serial link pins
    input wire sclk_i,
    input wire frame_sync_n_i,
    input wire serial_in_i,
    output wire serial_out_o,
    output reg serial_out_oe_o,
    // update and clear pins
    input wire load_outputs_n_i,
    input wire clear_outputs_n_i,
    input wire bipolar_coding_sel_i,
    // dac core side
    output reg [`DDS_DATA_W-1:0] dac_code_a_o,
    output reg [`DDS_DATA_W-1:0] dac_code_b_o,
    output reg [`DDS_RANGE_W-1:0] range_a_o,
    output reg [`DDS_RANGE_W-1:0] range_b_o,
    output reg [1:0] power_up_o,
    output reg frame_error_o
);

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function is_bipolar;
    input [`DDS_RANGE_W-1:0] rng;
    begin
        is_bipolar = (rng == `DDS_RANGE_BIP5) ||
                     (rng == `DDS_RANGE_BIP10) ||
                     (rng == `DDS_RANGE_BIP108);
    end
endfunction

// input word to straight binary code for the string dac
function [`DDS_DATA_W-1:0] to_code;
    input [`DDS_DATA_W-1:0] data;
    input [`DDS_RANGE_W-1:0] rng;
    input twos;
    begin
        if (is_bipolar(rng) && twos)
            to_code = data ^ `DDS_SIGN_FLIP;
        else
            to_code = data;
    end
endfunction

function ch_hit;
    input [2:0] ch;
    input idx;
    begin
        ch_hit = (ch == `DDS_CH_ALL) ||
                 (ch == (idx ? `DDS_CH_B : `DDS_CH_A));
    end
endfunction

// ----------------------------------------------------------------
// reset release and pin synchronisers
// ----------------------------------------------------------------
reg [1:0] rst_sync_r;
wire rst_n = rst_sync_r[1];

always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
        rst_sync_r <= 2'h0;
    else
        rst_sync_r <= {rst_sync_r[0], 1'b1};
end

// bit0 load, bit1 clear, bit2 coding select
reg [2:0] pin_s1_r;
reg [2:0] pin_s2_r;
reg load_d_r;

always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        pin_s1_r <= 3'h3;
        pin_s2_r <= 3'h3;
        load_d_r <= 1'b1;
    end else if (clk_en_i) begin
        pin_s1_r <= {bipolar_coding_sel_i, clear_outputs_n_i,
                     load_outputs_n_i};
        pin_s2_r <= pin_s1_r;
        load_d_r <= pin_s2_r[0];
    end
end

wire load_n = pin_s2_r[0];
wire clear_n = pin_s2_r[1];
wire twos_sel = pin_s2_r[2];
wire load_fall = load_d_r & ~load_n;

// ----------------------------------------------------------------
// link front end
// ----------------------------------------------------------------
wire frame_end;
wire frame_ok;
wire frame_idle;
wire [`DDS_FRAME_BITS-1:0] word;
reg rb_load_r;
reg [`DDS_FRAME_BITS-1:0] rb_word_r;

dds_frame_rx u_rx (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .clk_en_i(clk_en_i),
    .sclk_i(sclk_i),
    .frame_sync_n_i(frame_sync_n_i),
    .serial_in_i(serial_in_i),
    .load_i(rb_load_r),
    .load_word_i(rb_word_r),
    .frame_end_o(frame_end),
    .frame_ok_o(frame_ok),
    .word_o(word),
    .frame_idle_o(frame_idle),
    .serial_out_o(serial_out_o)
);

wire w_read = word[`DDS_RW_BIT];
wire [2:0] w_sel = word[`DDS_REG_HI:`DDS_REG_LO];
wire [2:0] w_ch = word[`DDS_CH_HI:`DDS_CH_LO];
wire [`DDS_DATA_W-1:0] w_data = word[`DDS_DATA_HI:`DDS_DATA_LO];

// ----------------------------------------------------------------
// register state
// ----------------------------------------------------------------
reg [`DDS_DATA_W-1:0] input_a_r;
reg [`DDS_DATA_W-1:0] input_b_r;
reg sdo_dis_r;
reg clr_sel_r;
reg read_active_r;

wire [`DDS_DATA_W-1:0] clr_code = clr_sel_r ? `DDS_CODE_MID :
                                              `DDS_CODE_ZERO;
wire valid = frame_end & frame_ok;
wire wr_dac = valid & ~w_read & (w_sel == `DDS_REG_DAC);
wire clr_cmd = valid & ~w_read & (w_sel == `DDS_REG_CTRL) &
               (w_ch == `DDS_CTRL_CLEAR);
// load level at frame close tells individual from simultaneous
wire indiv_upd = wr_dac & ~load_n;
wire all_upd = load_fall & frame_idle;
wire wr_a = wr_dac & ch_hit(w_ch, 1'b0) & power_up_o[`DDS_PWR_A_BIT];
wire wr_b = wr_dac & ch_hit(w_ch, 1'b1) & power_up_o[`DDS_PWR_B_BIT];

// readback source
reg [`DDS_DATA_W-1:0] rb_data;
always @* begin
    rb_data = `DDS_CODE_ZERO;
    case (w_sel)
        `DDS_REG_DAC:
            rb_data = (w_ch == `DDS_CH_B) ? input_b_r : input_a_r;
        `DDS_REG_RANGE:
            rb_data = {13'h0000,
                       (w_ch == `DDS_CH_B) ? range_b_o : range_a_o};
        `DDS_REG_POWER:
            rb_data = {14'h0000, power_up_o};
        `DDS_REG_CTRL:
            rb_data = {14'h0000, clr_sel_r, sdo_dis_r};
        default:
            rb_data = `DDS_CODE_ZERO;
    endcase
end

// ----------------------------------------------------------------
// frame decode and configuration
// ----------------------------------------------------------------
always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        // everything zero, powered down, 5 V unipolar
        input_a_r <= `DDS_CODE_ZERO;
        input_b_r <= `DDS_CODE_ZERO;
        range_a_o <= `DDS_RANGE_UNI5;
        range_b_o <= `DDS_RANGE_UNI5;
        power_up_o <= 2'h0;
        sdo_dis_r <= 1'b0;
        clr_sel_r <= 1'b0;
        read_active_r <= 1'b0;
        rb_load_r <= 1'b0;
        rb_word_r <= {`DDS_FRAME_BITS{1'b0}};
        frame_error_o <= 1'b0;
        serial_out_oe_o <= 1'b0;
    end else if (clk_en_i) begin
        rb_load_r <= 1'b0;
        frame_error_o <= frame_end & ~frame_ok;
        // enabled unless sdo disabled, else only through the frame after a read
        serial_out_oe_o <= ~sdo_dis_r | read_active_r;
        if (frame_end)
            read_active_r <= frame_ok & w_read;
        if (valid && w_read) begin
            rb_load_r <= 1'b1;
            rb_word_r <= {`DDS_RB_PAD, rb_data};
        end
        // powered-down channels keep their input value
        if (wr_a)
            input_a_r <= w_data;
        if (wr_b)
            input_b_r <= w_data;
        if (valid && !w_read) begin
            case (w_sel)
                `DDS_REG_RANGE: begin
                    if (ch_hit(w_ch, 1'b0))
                        range_a_o <= w_data[`DDS_RANGE_HI:0];
                    if (ch_hit(w_ch, 1'b1))
                        range_b_o <= w_data[`DDS_RANGE_HI:0];
                end
                `DDS_REG_POWER: begin
                    power_up_o <= {w_data[`DDS_PWR_B_BIT],
                                   w_data[`DDS_PWR_A_BIT]};
                end
                `DDS_REG_CTRL: begin
                    if (w_ch == `DDS_CTRL_SET) begin
                        sdo_dis_r <= w_data[`DDS_SDO_DIS_BIT];
                        clr_sel_r <= w_data[`DDS_CLR_SEL_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
    end
end

// ----------------------------------------------------------------
// dac registers: clear, individual and simultaneous update
// ----------------------------------------------------------------
always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        dac_code_a_o <= `DDS_CODE_ZERO;
        dac_code_b_o <= `DDS_CODE_ZERO;
    end else if (clk_en_i) begin
        if (!clear_n || clr_cmd) begin
            // clear wins, pin blocks every update
            dac_code_a_o <= clr_code;
            dac_code_b_o <= clr_code;
        end else if (all_upd) begin
            // load fall with sync high updates both
            dac_code_a_o <= to_code(input_a_r, range_a_o, twos_sel);
            dac_code_b_o <= to_code(input_b_r, range_b_o, twos_sel);
        end else if (indiv_upd) begin
            // addressed channel, coding by range and pin
            if (wr_a)
                dac_code_a_o <= to_code(w_data, range_a_o, twos_sel);
            if (wr_b)
                dac_code_b_o <= to_code(w_data, range_b_o, twos_sel);
        end
    end
end

endmodule

`default_nettype wire

// >>> dv/dds_serial_chk.sv
// port checker for the dual dac serial update control block
`default_nettype none
module dds_serial_chk (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // link and pins
    input wire logic frame_sync_n_i,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_o,
    input wire logic clear_outputs_n_i,
    // dac side
    input wire logic [15:0] dac_code_a_o,
    input wire logic [15:0] dac_code_b_o,
    input wire logic [2:0] range_a_o,
    input wire logic [2:0] range_b_o,
    input wire logic [1:0] power_up_o,
    input wire logic frame_error_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dds_cb @(posedge core_clk_i);
    endclocking
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_reset_zero: assert property (
        !reset_n_i [*2] |-> {range_a_o, range_b_o, power_up_o, dac_code_a_o,
        dac_code_b_o} == 40'h0) else $error("state not zero in reset");
    a_oe_release: assert property (disable iff (!reset_n_i)
        $rose(reset_n_i) |-> ##[1:4] serial_out_oe_o)
        else $error("serial out enable missing after reset");
    a_clear_force: assert property (disable iff (!reset_n_i)
        !clear_outputs_n_i [*5] |-> dac_code_a_o == dac_code_b_o &&
        (dac_code_a_o == 16'h0000 || dac_code_a_o == 16'h8000))
        else $error("clear did not force a clear code");
    a_clear_hold: assert property (disable iff (!reset_n_i)
        !clear_outputs_n_i [*6] |=> $stable(dac_code_a_o) &&
        $stable(dac_code_b_o)) else $error("code moved during clear");
    a_err_single: assert property (disable iff (!reset_n_i)
        frame_error_o |=> !frame_error_o)
        else $error("frame error longer than one cycle");
    a_err_closed: assert property (disable iff (!reset_n_i)
        frame_error_o |-> frame_sync_n_i && $past(frame_sync_n_i, 3))
        else $error("frame error without a closed frame");
    a_sdo_idle: assert property (disable iff (!reset_n_i)
        frame_sync_n_i [*6] |=> $stable(serial_out_o))
        else $error("serial out moved outside a frame");
    a_frame_hold: assert property (disable iff (!reset_n_i)
        (!frame_sync_n_i && clear_outputs_n_i) [*6] |=>
        $stable(dac_code_a_o) && $stable(dac_code_b_o))
        else $error("dac code moved while shifting");
    a_pwr_gate: assert property (disable iff (!reset_n_i)
        (!power_up_o[0] && clear_outputs_n_i) [*4] |=>
        $stable(dac_code_a_o)) else $error("powered-down code moved");
endmodule

bind dds_serial_ctrl dds_serial_chk u_chk (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .frame_sync_n_i(frame_sync_n_i),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
    .clear_outputs_n_i(clear_outputs_n_i), .dac_code_a_o(dac_code_a_o),
    .dac_code_b_o(dac_code_b_o), .range_a_o(range_a_o),
    .range_b_o(range_b_o), .power_up_o(power_up_o),
    .frame_error_o(frame_error_o));
`default_nettype wire

// >>> dv/dds_host_model.sv
// host serial port model that drives the link pins of the block
`default_nettype none
module dds_host_model (
    // clock reference
    input wire logic clk_i,
    // device serial output
    input wire logic serial_out_i,
    input wire logic serial_out_oe_i,
    // link pins toward the device
    output var logic sclk_o,
    output var logic frame_sync_n_o,
    output var logic serial_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // link clock stands high between frames
    initial begin
        sclk_o = 1'b1;
        frame_sync_n_o = 1'b1;
        serial_in_o = 1'b0;
    end
    // half of a 320 ns link period
    task automatic half_period();
        repeat (4) @(negedge clk_i);
    endtask
    // exact count of falls, 24 per chained device
    task automatic xfer(input logic [47:0] w, input int n,
            output logic [47:0] rx, output logic oe_all);
        rx = 48'h0;
        oe_all = 1'b1;
        frame_sync_n_o = 1'b0;
        // msb first, settled well before each fall
        serial_in_o = w[n-1];
        half_period();
        for (int i = n - 1; i >= 0; i--) begin
            // device output taken where a receiver's fall would take it
            rx = {rx[46:0], serial_out_i};
            sclk_o = 1'b0;
            half_period();
            sclk_o = 1'b1;
            // released line shows the inverse, never a stale copy
            serial_in_o = (i > 0) ? w[i-1] : ~w[0];
            half_period();
            oe_all = oe_all & serial_out_oe_i;
        end
        frame_sync_n_o = 1'b1;
        repeat (12) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// >>> dv/dds_serial_ctrl_bench.sv
// self-checking bench for the dual dac serial update control block
`default_nettype none
module dds_serial_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic sel;
        logic [23:0] frm;
        logic [39:0] exp;
    } dds_row_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic load_n = 1'b0;
    logic clear_n = 1'b1;
    logic coding_sel = 1'b0;
    logic sclk, sync_n, sdi, serial_out, sdo_oe, frame_err;
    logic [15:0] code_a, code_b;
    logic [2:0] range_a, range_b;
    logic [1:0] power_up;
    logic [39:0] st;
    logic [47:0] rx;
    logic oe_all;
    int fails = 0;
    int cmp_count = 0;
    int err_cnt = 0;
    // value before power on purpose, then power, range, values
    dds_row_t rows [9] = '{
        '{1'b0, 24'h001234, 40'h0000000000},
        '{1'b0, 24'h100003, 40'h0300000000},
        '{1'b0, 24'h090003, 40'h0F00000000},
        '{1'b0, 24'h001234, 40'h0F12340000},
        '{1'b0, 24'h017FFF, 40'h0F12347FFF},
        '{1'b0, 24'h04ABCD, 40'h0FABCDABCD},
        '{1'b0, 24'h180000, 40'h0FABCDABCD},
        '{1'b1, 24'h010001, 40'h0FABCD8001},
        '{1'b1, 24'h000001, 40'h0F00018001}
    };
    dds_serial_ctrl dut (
        .core_clk_i(clk), .clk_en_i(1'b1), .reset_n_i(reset_n),
        .sclk_i(sclk), .frame_sync_n_i(sync_n), .serial_in_i(sdi),
        .serial_out_o(serial_out), .serial_out_oe_o(sdo_oe),
        .load_outputs_n_i(load_n), .clear_outputs_n_i(clear_n),
        .bipolar_coding_sel_i(coding_sel),
        .dac_code_a_o(code_a), .dac_code_b_o(code_b),
        .range_a_o(range_a), .range_b_o(range_b),
        .power_up_o(power_up), .frame_error_o(frame_err)
    );
    dds_host_model host (
        .clk_i(clk), .serial_out_i(serial_out), .serial_out_oe_i(sdo_oe),
        .sclk_o(sclk), .frame_sync_n_o(sync_n), .serial_in_o(sdi)
    );
    assign st = {range_a, range_b, power_up, code_a, code_b};
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (frame_err === 1'b1)
            err_cnt <= err_cnt + 1;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [47:0] w, input int n);
        host.xfer(w, n, rx, oe_all);
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog, several times the expected run length
    initial begin
        wait_clk(20000);
        fails++;
        print_verdict();
    end
    initial begin
        wait_clk(6);
        reset_n = 1'b1;
        wait_clk(4);
        check({23'h0, sdo_oe, st}, {23'h0, 1'b1, 40'h0});
        foreach (rows[i]) begin
            coding_sel = rows[i].sel;
            send({24'h0, rows[i].frm}, 24);
            check({24'h0, st}, {24'h0, rows[i].exp});
        end
        $display("test rows done");
        send(48'h190001, 24);
        check({63'h0, sdo_oe}, 64'h0);
        send(48'h800000, 24);
        send(48'h180000, 24);
        check({38'h0, oe_all, sdo_oe, rx[23:0]}, 64'h2000001);
        $display("test readback done");
        send(48'h00FFFF, 23);
        send(48'h00FFFF, 25);
        send({24'h005555, 24'h00AAAA}, 48);
        check({rx[23:0], st}, {24'h005555, 40'h0F00018001});
        check(64'(err_cnt), 64'd3);
        $display("test frame count done");
        load_n = 1'b1;
        send(48'h002222, 24);
        check({24'h0, st}, {24'h0, 40'h0F00018001});
        load_n = 1'b0;
        wait_clk(10);
        check({24'h0, st}, {24'h0, 40'h0F22228001});
        $display("test load strobe done");
        send(48'h190002, 24);
        clear_n = 1'b0;
        wait_clk(8);
        check({24'h0, st}, {24'h0, 40'h0F80008000});
        send(48'h003333, 24);
        clear_n = 1'b1;
        wait_clk(8);
        check({24'h0, st}, {24'h0, 40'h0F80008000});
        send(48'h190000, 24);
        send(48'h004444, 24);
        send(48'h1C0000, 24);
        check({24'h0, st}, {24'h0, 40'h0F00000000});
        $display("test clear done");
        reset_n = 1'b0;
        wait_clk(2);
        check({24'h0, st}, 64'h0);
        reset_n = 1'b1;
        wait_clk(4);
        send(48'h001234, 24);
        check({24'h0, st}, 64'h0);
        $display("test second reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
